// [hdl/cmpb_control.sv]
// Comparator B control, shared reference and clock select registers
//
// Behaviour
// - The input-connect bit ties the one selected analog pin to comparator B, else none.
// - Hardware sets the event flag when the output meets the selected mode condition.
// - Only a software write clears the flag; bit 6 of the enable register gates its irq.
// - With enable clear the output is held low and no event sets the flag.
// - While enabled, the four analog port pins are forced to input-only.
// - Mode 0..7 is low, rise, dbc toggle, dbc rise, fall, toggle, dbc fall, high.
// - On the system clock, debounced modes time their delay from timer 1 overflows; on a timer clock they do not debounce.
// - B negative select picks analog input 2, ref minus delta, ref, ref plus delta.
// - A negative select picks analog input 1, ref minus delta, ref, ref plus delta.
// - The reference and clock select register resets to all zeros.
// - A debounced system-clock edge waits two timer 1 overflows, then resamples.
// - On a timer sample clock a change must hold four samples to count as an edge.
`timescale 1ns/10ps
module cmpb_control (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire cmpb_pkg::cmpb_bus_type bus_req,
    output logic [7:0] bus_rdata,
    // Comparator and timers
    input wire logic cmp_b_raw,
    input wire logic tmr0_ovf,
    input wire logic tmr1_ovf,
    input wire logic tmr2_ovf,
    // Analog steering
    output logic [1:0] cmp_b_positive_select,
    output logic [1:0] cmp_b_negative_select,
    output logic [1:0] cmp_a_negative_select,
    output logic [1:0] cmp_a_sample_clock_select,
    output logic cmp_a_sample_en,
    output logic cmp_b_input_connect,
    output logic [3:0] analog_input_connect,
    output logic [3:0] port_input_only,
    // Results
    output logic cmp_b_output,
    output logic cmp_irq,
    output logic irq
);
    import cmpb_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    cmpb_ctrl_type ctrl_q;
    cmpb_ctrl_type ctrl_w;
    cmpb_ref_type ref_q;
    logic [7:0] ie_q;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [2:0] mask_q;
    logic [7:0] rdata_q;
    logic sync1_q;
    logic sync2_q;
    logic out_q;
    logic smp_en;
    logic lvl;
    logic evt;
    logic reject;
    logic change;
    logic wr_ctrl;
    logic wr_ref;
    logic wr_ie;
    logic wr_mask;
    logic rd_stat;
    logic flag_clr;

    // Pick the sampling strobe for a clock select code
    function automatic logic pick_clk(input logic [1:0] sel,
                                      input logic t0,
                                      input logic t1,
                                      input logic t2);
        logic r;
        r = 1'b1;
        unique case (sel)
            CMPB_CLK_SYS: r = 1'b1;
            CMPB_CLK_T0: r = t0;
            CMPB_CLK_T1: r = t1;
            CMPB_CLK_T2: r = t2;
        endcase
        return r;
    endfunction

    // ************************************************************
    // Register port decode
    // ************************************************************

    // Write and read strobes per register
    assign wr_ctrl = bus_req.wr && bus_req.addr == CMPB_OFS_CTRL;
    assign wr_ref = bus_req.wr && bus_req.addr == CMPB_OFS_REF;
    assign wr_ie = bus_req.wr && bus_req.addr == CMPB_OFS_IE;
    assign wr_mask = bus_req.wr && bus_req.addr == CMPB_OFS_MASK;
    assign rd_stat = bus_req.rd && bus_req.addr == CMPB_OFS_STAT;
    assign ctrl_w = cmpb_ctrl_type'(bus_req.wdata);
    assign flag_clr = wr_ctrl && !bus_req.wdata[CMPB_FLAG_BIT];

    // ************************************************************
    // Comparator input synchroniser
    // ************************************************************

    // Two stages; only the second one is read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= cmp_b_raw;
            sync2_q <= sync1_q;
        end
    end

    // ************************************************************
    // Sampling and event detection
    // ************************************************************

    // Sampling strobes of both comparators
    assign smp_en = pick_clk(ref_q.b_clk, tmr0_ovf, tmr1_ovf, tmr2_ovf);
    assign cmp_a_sample_en = pick_clk(ref_q.a_clk, tmr0_ovf, tmr1_ovf, tmr2_ovf);

    // Filter, debouncer and mode decoder
    cmpb_event_unit u_event (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .enable(ctrl_q.enable),
        .sys_sel(ref_q.b_clk == CMPB_CLK_SYS),
        .mode(ctrl_q.mode),
        .sample_en(smp_en),
        .sample(sync2_q & ctrl_q.enable),
        .t1_ovf(tmr1_ovf),
        .level(lvl),
        .evt(evt),
        .reject(reject),
        .change(change)
    );

    // ************************************************************
    // Control and status register
    // ************************************************************

    // Software fields follow writes; a hardware flag set wins over a software clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= cmpb_ctrl_type'(CMPB_RST_CTRL);
        end else begin
            if (wr_ctrl) begin
                ctrl_q.pos_sel <= ctrl_w.pos_sel;
                ctrl_q.connect <= ctrl_w.connect;
                ctrl_q.enable <= ctrl_w.enable;
                ctrl_q.mode <= ctrl_w.mode;
            end
            if (evt) begin
                ctrl_q.flag <= 1'b1;
            end else if (flag_clr) begin
                ctrl_q.flag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Reference, clock select and enable registers
    // ************************************************************

    // Shared reference and clock select
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ref_q <= cmpb_ref_type'(CMPB_RST_REF);
        end else if (wr_ref) begin
            ref_q <= cmpb_ref_type'(bus_req.wdata);
        end
    end

    // Interrupt enable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ie_q <= CMPB_RST_IE;
        end else if (wr_ie) begin
            ie_q <= bus_req.wdata;
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************

    // Sticky status, cleared by a read; new events win
    always_comb begin
        stat_d = rd_stat ? 3'h0 : stat_q;
        stat_d[CMPB_EV_FLAG] = stat_d[CMPB_EV_FLAG] | evt;
        stat_d[CMPB_EV_REJECT] = stat_d[CMPB_EV_REJECT] | reject;
        stat_d[CMPB_EV_CHANGE] = stat_d[CMPB_EV_CHANGE] | change;
    end

    // Status register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stat_q <= CMPB_RST_IRQ;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Mask register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_q <= CMPB_RST_IRQ;
        end else if (wr_mask) begin
            mask_q <= bus_req.wdata[2:0];
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************

    // Registered read answer, zero for unmapped offsets
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                CMPB_OFS_CTRL: rdata_q <= ctrl_q;
                CMPB_OFS_REF: rdata_q <= ref_q;
                CMPB_OFS_IE: rdata_q <= ie_q;
                CMPB_OFS_STAT: rdata_q <= {5'h00, stat_q};
                CMPB_OFS_MASK: rdata_q <= {5'h00, mask_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign bus_rdata = rdata_q;

    // ************************************************************
    // Outputs
    // ************************************************************

    // Comparator output, forced low while disabled
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= ctrl_q.enable & lvl;
        end
    end
    assign cmp_b_output = out_q;

    // Analog steering
    assign cmp_b_input_connect = ctrl_q.connect;
    assign cmp_b_positive_select = ctrl_q.pos_sel;
    assign analog_input_connect = ctrl_q.connect ? (4'h1 << ctrl_q.pos_sel) : 4'h0;
    assign cmp_b_negative_select = ref_q.b_neg;
    assign cmp_a_negative_select = ref_q.a_neg;
    assign cmp_a_sample_clock_select = ref_q.a_clk;
    assign port_input_only = {4{ctrl_q.enable}};

    // Interrupt lines
    assign cmp_irq = ctrl_q.flag & ie_q[CMPB_IE_CMP_BIT];
    assign irq = |(stat_q & mask_q);

    // ************************************************************
    // Assertions
    // ************************************************************

    a_pin_connect:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        !ctrl_q.connect |-> analog_input_connect == 4'h0)
    else $error("pins connected while connect bit clear");

    a_flag_set:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        evt |=> ctrl_q.flag && stat_q[CMPB_EV_FLAG])
    else $error("event did not set flag");

    a_flag_hold:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (ctrl_q.flag && !flag_clr) |=> ctrl_q.flag)
    else $error("flag cleared without write");

    a_irq_gate:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        cmp_irq == (ctrl_q.flag && ie_q[6]))
    else $error("comparator irq not gated by enable bit 6");

    a_disable_low:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (!ctrl_q.enable && $past(!ctrl_q.enable)) |-> !cmp_b_output)
    else $error("output not low while disabled");

    a_no_set_off:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (!ctrl_q.enable && !ctrl_q.flag) |=> !ctrl_q.flag)
    else $error("flag set while disabled");

    a_input_only:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_q.enable |-> port_input_only == 4'hf)
    else $error("pins not input-only while enabled");

    a_t1_sample:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (ref_q.b_clk == 2'h2) |-> (smp_en == tmr1_ovf))
    else $error("timer 1 clock select not honoured");

    a_sys_sample:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (ref_q.b_clk == 2'h0) |-> smp_en)
    else $error("system clock select not sampling every cycle");

    a_level_high:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (ctrl_q.enable && ctrl_q.mode == 3'h7 && ref_q.b_clk == 2'h0 && lvl)
            |-> evt)
    else $error("high level mode missed an event");

    a_read_clear:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (rd_stat && !evt && !reject && !change) |=> stat_q == 3'h0)
    else $error("status not cleared by read");

    a_pin_select:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_q.connect |-> ($onehot(analog_input_connect) && analog_input_connect[ctrl_q.pos_sel]))
    else $error("selected pin not the only one connected");

    a_flag_clear:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (flag_clr && !evt) |=> !ctrl_q.flag)
    else $error("flag not cleared by write");

    a_out_follow:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_q.enable |=> cmp_b_output == $past(lvl))
    else $error("output does not follow comparator level");

    a_no_evt_off:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        !ctrl_q.enable |-> !(evt || reject || change))
    else $error("event raised while disabled");
endmodule // cmpb_control

// [hdl/cmpb_event_unit.sv]
// Sample filter, debouncer and interrupt mode decoder of comparator B
`timescale 1ns/10ps
module cmpb_event_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Control
    input wire logic enable,
    input wire logic sys_sel,
    input wire logic [2:0] mode,
    // Samples
    input wire logic sample_en,
    input wire logic sample,
    input wire logic t1_ovf,
    // Results
    output logic level,
    output logic evt,
    output logic reject,
    output logic change
);
    import cmpb_pkg::*;
    localparam logic [1:0] FILT_LAST = 2'(CMPB_FILT_SAMPLES - 1);
    localparam logic [1:0] OVF_LAST = 2'(CMPB_DBC_OVF - 1);
    logic cur_q;
    logic acc_q;
    logic [1:0] cnt_q;
    logic exp_q;
    logic [1:0] ovf_q;
    cmpb_dbc_state_type st_q;
    logic edge_hit;
    logic rel;
    logic dbc_mode;
    logic lvl_mode;
    logic want;
    logic dbc_start;
    logic dbc_done;

    // Edge of raw samples, or of filtered samples on a timer clock
    assign level = sys_sel ? cur_q : acc_q;
    assign edge_hit = sample_en && (sys_sel ? (sample != cur_q)
        : (sample != acc_q && cnt_q == FILT_LAST));
    assign change = enable && edge_hit;

    // Mode decode
    always_comb begin
        rel = 1'b0;
        dbc_mode = 1'b0;
        lvl_mode = 1'b0;
        want = 1'b0;
        unique case (mode)
            CMPB_MODE_LOW: lvl_mode = 1'b1;
            CMPB_MODE_RISE: rel = sample;
            CMPB_MODE_DBC_TOG: begin
                rel = 1'b1;
                dbc_mode = 1'b1;
            end
            CMPB_MODE_DBC_RISE: begin
                rel = sample;
                dbc_mode = 1'b1;
            end
            CMPB_MODE_FALL: rel = !sample;
            CMPB_MODE_TOG: rel = 1'b1;
            CMPB_MODE_DBC_FALL: begin
                rel = !sample;
                dbc_mode = 1'b1;
            end
            CMPB_MODE_HIGH: begin
                lvl_mode = 1'b1;
                want = 1'b1;
            end
        endcase
    end

    // Debounce start and decision on the second timer 1 overflow
    assign dbc_start = edge_hit && rel && dbc_mode && sys_sel && st_q == CMPB_DBC_IDLE;
    assign dbc_done = st_q == CMPB_DBC_WAIT && t1_ovf && ovf_q == OVF_LAST;
    assign evt = enable && ((lvl_mode && sample_en && level == want)
        || (!lvl_mode && edge_hit && rel && !(dbc_mode && sys_sel))
        || (dbc_done && cur_q == exp_q));
    assign reject = enable && dbc_done && cur_q != exp_q;

    // Sample register and four-sample filter
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur_q <= 1'b0;
            acc_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (sample_en) begin
            cur_q <= sample;
            if (sample == acc_q || cnt_q == FILT_LAST) begin
                cnt_q <= 2'h0;
                acc_q <= sample;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // Debounce wait state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= CMPB_DBC_IDLE;
            exp_q <= 1'b0;
            ovf_q <= 2'h0;
        end else if (!enable || !dbc_mode || !sys_sel || dbc_done) begin
            st_q <= CMPB_DBC_IDLE;
            ovf_q <= 2'h0;
        end else if (dbc_start) begin
            st_q <= CMPB_DBC_WAIT;
            exp_q <= sample;
            ovf_q <= 2'h0;
        end else if (st_q == CMPB_DBC_WAIT && t1_ovf) begin
            ovf_q <= ovf_q + 2'h1;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_dbc_two_ovf:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (dbc_mode && sys_sel && !lvl_mode && evt) |-> (t1_ovf && ovf_q == OVF_LAST))
    else $error("debounced event without second overflow");

    a_filt_four:
    assert property (@(posedge clk_sys) disable iff (!rstn)
        (!sys_sel && edge_hit) |-> (sample_en && cnt_q == 2'h3))
    else $error("timer clock edge accepted before four samples");
endmodule // cmpb_event_unit

// [inc/cmpb_pkg.sv]
// Constants and types shared by the comparator B control block
package cmpb_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] CMPB_OFS_CTRL = 8'h9f;
    localparam logic [7:0] CMPB_OFS_REF = 8'haf;
    localparam logic [7:0] CMPB_OFS_STAT = 8'hb0;
    localparam logic [7:0] CMPB_OFS_MASK = 8'hb1;
    localparam logic [7:0] CMPB_OFS_IE = 8'hb2;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] CMPB_RST_CTRL = 8'hc0;
    localparam logic [7:0] CMPB_RST_REF = 8'h00;
    localparam logic [7:0] CMPB_RST_IE = 8'h00;
    localparam logic [2:0] CMPB_RST_IRQ = 3'h0;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CMPB_FLAG_BIT = 4;
    localparam int CMPB_IE_CMP_BIT = 6;
    localparam int CMPB_EV_FLAG = 0;
    localparam int CMPB_EV_REJECT = 1;
    localparam int CMPB_EV_CHANGE = 2;
    // ************************************************************
    // Timing counts
    // ************************************************************
    localparam int CMPB_DBC_OVF = 2;
    localparam int CMPB_FILT_SAMPLES = 4;
    // ************************************************************
    // Interrupt modes and sample clock selects
    // ************************************************************
    localparam logic [2:0] CMPB_MODE_LOW = 3'h0;
    localparam logic [2:0] CMPB_MODE_RISE = 3'h1;
    localparam logic [2:0] CMPB_MODE_DBC_TOG = 3'h2;
    localparam logic [2:0] CMPB_MODE_DBC_RISE = 3'h3;
    localparam logic [2:0] CMPB_MODE_FALL = 3'h4;
    localparam logic [2:0] CMPB_MODE_TOG = 3'h5;
    localparam logic [2:0] CMPB_MODE_DBC_FALL = 3'h6;
    localparam logic [2:0] CMPB_MODE_HIGH = 3'h7;
    localparam logic [1:0] CMPB_CLK_SYS = 2'h0;
    localparam logic [1:0] CMPB_CLK_T0 = 2'h1;
    localparam logic [1:0] CMPB_CLK_T1 = 2'h2;
    localparam logic [1:0] CMPB_CLK_T2 = 2'h3;
    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [1:0] pos_sel;
        logic connect;
        logic flag;
        logic enable;
        logic [2:0] mode;
    } cmpb_ctrl_type;
    typedef struct packed {
        logic [1:0] b_clk;
        logic [1:0] b_neg;
        logic [1:0] a_clk;
        logic [1:0] a_neg;
    } cmpb_ref_type;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmpb_bus_type;
    typedef enum logic {CMPB_DBC_IDLE, CMPB_DBC_WAIT} cmpb_dbc_state_type;
endpackage

// [test/cmpb_control_bench.sv]
// Self-checking testbench for the comparator B control block
`timescale 1ns/10ps
module cmpb_control_bench;
    import cmpb_pkg::*;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    cmpb_bus_type bus_req = '0;
    logic cmp_b_raw = 1'b0;
    logic [2:0] tmr_ovf = 3'h0;
    logic [7:0] bus_rdata;
    logic [1:0] pos_sel, b_neg, a_neg, a_clk;
    logic a_sen, b_conn, b_out, cmp_irq, irq;
    logic [3:0] ain_conn, pin_only;
    int err_count = 0;
    int cmp_count = 0;
    cmpb_control dut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .cmp_b_raw(cmp_b_raw), .tmr0_ovf(tmr_ovf[0]), .tmr1_ovf(tmr_ovf[1]),
        .tmr2_ovf(tmr_ovf[2]), .cmp_b_positive_select(pos_sel), .cmp_b_negative_select(b_neg),
        .cmp_a_negative_select(a_neg), .cmp_a_sample_clock_select(a_clk),
        .cmp_a_sample_en(a_sen), .cmp_b_input_connect(b_conn), .analog_input_connect(ain_conn),
        .port_input_only(pin_only), .cmp_b_output(b_out), .cmp_irq(cmp_irq), .irq(irq));
    // Clock at 50 MHz
    always #10 clk_sys = ~clk_sys;
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic raw(input logic v);
        @(posedge clk_sys);
        cmp_b_raw <= v;
        #1;
    endtask
    task automatic tick(input int i);
        @(posedge clk_sys);
        tmr_ovf[i] <= 1'b1;
        @(posedge clk_sys);
        tmr_ovf[i] <= 1'b0;
        #1;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rchk(CMPB_OFS_REF, 8'h00);
        rchk(CMPB_OFS_CTRL, CMPB_RST_CTRL);
        rchk(CMPB_OFS_IE, 8'h00);
        rchk(8'h55, 8'h00);
        chk({6'h00, a_clk}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_steer();
        logic [1:0] p;
        for (int i = 0; i < 4; i++) begin
            p = i[1:0];
            wr(CMPB_OFS_CTRL, {p, 6'h20});
            chk({4'h0, ain_conn}, 8'h01 << i);
            chk({6'h00, pos_sel}, {6'h00, p});
            chk({7'h00, b_conn}, 8'h01);
            wr(CMPB_OFS_CTRL, {p, 6'h00});
            chk({4'h0, ain_conn}, 8'h00);
        end
        wr(CMPB_OFS_CTRL, 8'h08);
        chk({4'h0, pin_only}, 8'h0f);
        wr(CMPB_OFS_CTRL, 8'h00);
        chk({4'h0, pin_only}, 8'h00);
        $display("test steering done");
    endtask
    task automatic t_ref();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(CMPB_OFS_REF, {c, c, c, c});
            chk({6'h00, b_neg}, {6'h00, c});
            chk({6'h00, a_neg}, {6'h00, c});
            chk({6'h00, a_clk}, {6'h00, c});
        end
        wr(CMPB_OFS_REF, 8'h00);
        chk({7'h00, a_sen}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(CMPB_OFS_REF, 8'(4 * (i + 1)));
            chk({7'h00, a_sen}, 8'h00);
            @(posedge clk_sys);
            tmr_ovf[i] <= 1'b1;
            #1 chk({7'h00, a_sen}, 8'h01);
            @(posedge clk_sys);
            tmr_ovf[i] <= 1'b0;
        end
        wr(CMPB_OFS_REF, 8'h00);
        $display("test reference done");
    endtask
    task automatic t_modes();
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 8'(i);
            wr(CMPB_OFS_CTRL, m);
            raw(1'b0);
            cyc(4);
            wr(CMPB_OFS_CTRL, 8'h08 | m);
            raw(1'b1);
            cyc(5);
            rchk(CMPB_OFS_CTRL, (8'h08 | m) | ((i inside {0, 1, 5, 7}) ? 8'h10 : 8'h00));
            wr(CMPB_OFS_CTRL, 8'h08 | m);
            raw(1'b0);
            cyc(5);
            rchk(CMPB_OFS_CTRL, (8'h08 | m) | ((i inside {0, 4, 5, 7}) ? 8'h10 : 8'h00));
        end
        $display("test modes done");
    endtask
    task automatic t_disable();
        wr(CMPB_OFS_CTRL, 8'h07);
        raw(1'b1);
        cyc(5);
        chk({7'h00, b_out}, 8'h00);
        rchk(CMPB_OFS_CTRL, 8'h07);
        wr(CMPB_OFS_CTRL, 8'h0f);
        cyc(4);
        chk({7'h00, b_out}, 8'h01);
        rchk(CMPB_OFS_CTRL, 8'h1f);
        wr(CMPB_OFS_CTRL, 8'h01);
        raw(1'b0);
        $display("test disable done");
    endtask
    task automatic t_irq();
        logic [7:0] d;
        wr(CMPB_OFS_CTRL, 8'h09);
        rd(CMPB_OFS_STAT, d);
        raw(1'b1);
        cyc(4);
        chk({6'h00, cmp_irq, irq}, 8'h00);
        wr(CMPB_OFS_IE, 8'h40);
        wr(CMPB_OFS_MASK, 8'h01);
        chk({6'h00, cmp_irq, irq}, 8'h03);
        rd(CMPB_OFS_STAT, d);
        chk(d, 8'h05);
        chk({6'h00, cmp_irq, irq}, 8'h02);
        wr(CMPB_OFS_CTRL, 8'h19);
        rchk(CMPB_OFS_CTRL, 8'h19);
        wr(CMPB_OFS_CTRL, 8'h09);
        rchk(CMPB_OFS_CTRL, 8'h09);
        chk({7'h00, cmp_irq}, 8'h00);
        $display("test interrupt done");
    endtask
    task automatic t_debounce();
        logic [7:0] d;
        wr(CMPB_OFS_CTRL, 8'h03);
        raw(1'b0);
        cyc(4);
        wr(CMPB_OFS_CTRL, 8'h0b);
        rd(CMPB_OFS_STAT, d);
        raw(1'b1);
        cyc(4);
        tick(1);
        cyc(2);
        rchk(CMPB_OFS_CTRL, 8'h0b);
        tick(1);
        cyc(2);
        rchk(CMPB_OFS_CTRL, 8'h1b);
        wr(CMPB_OFS_CTRL, 8'h0b);
        raw(1'b0);
        cyc(4);
        raw(1'b1);
        cyc(4);
        raw(1'b0);
        cyc(4);
        tick(1);
        tick(1);
        cyc(2);
        rchk(CMPB_OFS_CTRL, 8'h0b);
        rd(CMPB_OFS_STAT, d);
        chk(d & 8'h02, 8'h02);
        $display("test debounce done");
    endtask
    task automatic t_filter();
        wr(CMPB_OFS_CTRL, 8'h01);
        wr(CMPB_OFS_REF, 8'h40);
        wr(CMPB_OFS_CTRL, 8'h09);
        raw(1'b1);
        cyc(4);
        repeat (3) tick(0);
        cyc(2);
        rchk(CMPB_OFS_CTRL, 8'h09);
        chk({7'h00, b_out}, 8'h00);
        tick(0);
        cyc(2);
        rchk(CMPB_OFS_CTRL, 8'h19);
        chk({7'h00, b_out}, 8'h01);
        $display("test filter done");
    endtask
    // ************************************************************
    // Sequence, watchdog and verdict
    // ************************************************************
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence after two cycles of reset
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_steer();
        t_ref();
        t_modes();
        t_disable();
        t_irq();
        t_debounce();
        t_filter();
        stop_test();
    end
    // Watchdog well beyond the expected run of about 400 cycles
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
endmodule // cmpb_control_bench
